/* design/cts_pkg.sv */
// constants, register map and types of the commutation threshold and
// switch-mode configuration block.
// assumes a 32-bit AHB-Lite register bus and a 125 MHz system clock.
package cts_pkg;
   // printed offsets are register indices; byte address is index times four
   localparam logic [7:0] CTS_IDX_COMM_THRESH = 8'h29;
   localparam logic [7:0] CTS_IDX_SWITCH_MODE_CONFIG = 8'h2A;
   localparam logic [7:0] CTS_IDX_STATUS = 8'h30;
   localparam logic [7:0] CTS_IDX_VSTOP_LEFT = 8'h31;
   localparam logic [7:0] CTS_IDX_VSTOP_RIGHT = 8'h32;
   localparam int CTS_AW = 10;
   localparam logic [9:0] CTS_ADDR_COMM_THRESH = {CTS_IDX_COMM_THRESH, 2'b00};
   localparam logic [9:0] CTS_ADDR_SWITCH_MODE_CONFIG = {CTS_IDX_SWITCH_MODE_CONFIG, 2'b00};
   localparam logic [9:0] CTS_ADDR_STATUS = {CTS_IDX_STATUS, 2'b00};
   localparam logic [9:0] CTS_ADDR_VSTOP_LEFT = {CTS_IDX_VSTOP_LEFT, 2'b00};
   localparam logic [9:0] CTS_ADDR_VSTOP_RIGHT = {CTS_IDX_VSTOP_RIGHT, 2'b00};
   localparam logic [2:0] CTS_HSIZE_WORD = 3'h2;
   // threshold field: only bits 22:8 exist
   localparam int CTS_THR_LSB = 8;
   localparam int CTS_THR_MSB = 22;
   localparam int CTS_THR_W = CTS_THR_MSB - CTS_THR_LSB + 1;
   localparam logic [CTS_THR_W-1:0] CTS_THR_RESET = 15'h0;
   // switch-mode fields
   localparam int CTS_SW_W = 15;
   localparam logic [CTS_SW_W-1:0] CTS_SW_RESET = 15'h0;
   localparam int CTS_SW_STOP_L = 0;
   localparam int CTS_SW_STOP_R = 1;
   localparam int CTS_SW_POL_L = 2;
   localparam int CTS_SW_POL_R = 3;
   localparam int CTS_SW_SWAP = 4;
   localparam int CTS_SW_STALL_STOP = 10;
   localparam int CTS_SW_VSTOP_L = 12;
   localparam int CTS_SW_VSTOP_R = 13;
   localparam int CTS_SW_VSTOP_ENC = 14;
   localparam logic [31:0] CTS_LIMIT_RESET = 32'h0;
   // status fields
   localparam int CTS_ST_COMM = 0;
   localparam int CTS_ST_STOP_L = 1;
   localparam int CTS_ST_STOP_R = 2;
   localparam int CTS_ST_VSTOP_L = 3;
   localparam int CTS_ST_VSTOP_R = 4;
   localparam int CTS_ST_MOTOR_STOP = 5;

   typedef enum logic [1:0]
   {
      CTS_BUS_IDLE = 2'b00,
      CTS_BUS_WAIT = 2'b01,
      CTS_BUS_DONE = 2'b10
   } cts_bus_state_e;
endpackage

/* design/cts_ahb_slave.sv */
// AHB-Lite slave front end: one wait state per transfer, read data
// registered. assumes a single master and the block's register mux.
`timescale 1ns/100ps
module cts_ahb_slave
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic o_hreadyout,
   output logic o_hresp,
   output logic [31:0] o_hrdata,
   output logic o_wr_en,
   output logic o_rd_en,
   output logic [cts_pkg::CTS_AW-1:0] o_addr,
   output logic [31:0] o_wdata,
   input wire logic [31:0] i_rdata
);
   import cts_pkg::*;

   cts_bus_state_e state_q, state_d;
   logic [CTS_AW-1:0] addr_q, addr_d;
   logic wr_q, wr_d;
   logic ok_q, ok_d;
   logic [31:0] rdata_q, rdata_d;
   logic take;

   ////////////////////////////////////////////////////////////////////////
   assign take = i_hsel & i_htrans[1] & i_hready;

   always_comb
   begin
      state_d = state_q;
      addr_d = addr_q;
      wr_d = wr_q;
      ok_d = ok_q;
      rdata_d = rdata_q;
      unique case (state_q)
         CTS_BUS_IDLE, CTS_BUS_DONE:
         begin
            state_d = CTS_BUS_IDLE;
            if (take)
            begin
               state_d = CTS_BUS_WAIT;
               addr_d = i_haddr[CTS_AW-1:0];
               wr_d = i_hwrite;
               // only aligned whole words reach the registers
               ok_d = (i_hsize == CTS_HSIZE_WORD) && (i_haddr[1:0] == 2'h0);
            end
         end
         CTS_BUS_WAIT:
         begin
            state_d = CTS_BUS_DONE;
            rdata_d = (wr_q || !ok_q) ? 32'h0 : i_rdata;
         end
         default:
         begin
            state_d = CTS_BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         state_q <= CTS_BUS_IDLE;
         addr_q <= '0;
         wr_q <= 1'b0;
         ok_q <= 1'b0;
         rdata_q <= 32'h0;
      end
      else
      begin
         state_q <= state_d;
         addr_q <= addr_d;
         wr_q <= wr_d;
         ok_q <= ok_d;
         rdata_q <= rdata_d;
      end
   end

   assign o_hreadyout = (state_q != CTS_BUS_WAIT);
   assign o_hresp = 1'b0;
   assign o_hrdata = rdata_q;
   assign o_wr_en = (state_q == CTS_BUS_WAIT) & wr_q & ok_q;
   assign o_rd_en = (state_q == CTS_BUS_WAIT) & ~wr_q & ok_q;
   assign o_addr = addr_q;
   assign o_wdata = i_hwdata;

   a_one_wait_state: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      take |=> !o_hreadyout ##1 o_hreadyout)
      else $error("transfer did not complete after one wait state");
endmodule

/* design/cts_ref_switch.sv */
// reference switch and virtual stop evaluation for left and right sides.
// assumes reference inputs synchronous to i_clk and signed positions.
`timescale 1ns/100ps
module cts_ref_switch
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_left_ref_input,
   input wire logic i_right_ref_input,
   input wire logic [cts_pkg::CTS_SW_W-1:0] i_switch_mode_config,
   input wire logic [31:0] i_ramp_actual_position,
   input wire logic [31:0] i_encoder_position,
   input wire logic [31:0] i_vstop_left_limit,
   input wire logic [31:0] i_vstop_right_limit,
   output logic [1:0] o_stop,
   output logic [1:0] o_vstop_active,
   output logic o_motor_stop
);
   import cts_pkg::*;

   logic [1:0] stop_q, stop_d;
   logic [1:0] vst_q, vst_d;
   logic [1:0] ref_raw;
   logic [1:0] ref_act;
   logic [31:0] vpos;

   ////////////////////////////////////////////////////////////////////////
   assign vpos = i_switch_mode_config[CTS_SW_VSTOP_ENC] ? i_encoder_position
                                              : i_ramp_actual_position;
   assign ref_raw[0] = i_switch_mode_config[CTS_SW_SWAP] ? i_right_ref_input
                                               : i_left_ref_input;
   assign ref_raw[1] = i_switch_mode_config[CTS_SW_SWAP] ? i_left_ref_input
                                               : i_right_ref_input;
   // left limit stops at or below, right limit at or above
   assign vst_d[0] = $signed(vpos) <= $signed(i_vstop_left_limit);
   assign vst_d[1] = $signed(vpos) >= $signed(i_vstop_right_limit);

   // side 0 is left, side 1 is right; field bits sit one apart per side
   for (genvar s = 0; s < 2; s++)
   begin : g_side
      assign ref_act[s] = ref_raw[s] ^ i_switch_mode_config[CTS_SW_POL_L + s];
      // stop holds only while the cause lasts, so release resumes motion
      assign stop_d[s] =
         (i_switch_mode_config[CTS_SW_STOP_L + s] & ref_act[s])
         | (i_switch_mode_config[CTS_SW_VSTOP_L + s] & vst_d[s]);
   end

   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         stop_q <= 2'h0;
         vst_q <= 2'h0;
      end
      else
      begin
         stop_q <= stop_d;
         vst_q <= vst_d;
      end
   end

   assign o_stop = stop_q;
   assign o_vstop_active = vst_q;
   assign o_motor_stop = |stop_q;

   a_ref_left_stop: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      (i_switch_mode_config[CTS_SW_STOP_L] && !i_switch_mode_config[CTS_SW_SWAP]
       && (i_left_ref_input != i_switch_mode_config[CTS_SW_POL_L]))
      |=> o_stop[0] && o_motor_stop)
      else $error("left switch did not stop the motor");
   a_ref_swap_pol: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      (i_switch_mode_config[CTS_SW_SWAP] && !i_switch_mode_config[CTS_SW_VSTOP_R]
       && (i_left_ref_input == i_switch_mode_config[CTS_SW_POL_R]))
      |=> !o_stop[1])
      else $error("swapped right side stopped on inactive level");
   a_vstop_right: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      (i_switch_mode_config[CTS_SW_VSTOP_R] && !i_switch_mode_config[CTS_SW_VSTOP_ENC]
       && ($signed(i_ramp_actual_position) >= $signed(i_vstop_right_limit)))
      |=> o_stop[1] && o_vstop_active[1])
      else $error("right virtual stop missed on ramp position");
   a_vstop_encoder: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      (i_switch_mode_config[CTS_SW_VSTOP_ENC]
       && ($signed(i_encoder_position) > $signed(i_vstop_left_limit)))
      |=> !o_vstop_active[0])
      else $error("left virtual stop not taken from encoder");
endmodule

/* design/cts_commutation_cfg.sv */
// commutation velocity threshold and switch-mode configuration block.
// assumes ramp generator, encoder and commutation sensing are outside.
`timescale 1ns/100ps
module cts_commutation_cfg
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic o_hreadyout,
   output logic o_hresp,
   output logic [31:0] o_hrdata,
   input wire logic [31:0] i_actual_velocity,
   input wire logic i_internal_ramp_mode,
   input wire logic i_step_dir_mode,
   input wire logic [31:0] i_commutation_position,
   input wire logic [31:0] i_commutation_velocity,
   input wire logic [31:0] i_ramp_actual_position,
   input wire logic [31:0] i_encoder_position,
   input wire logic i_left_ref_input,
   input wire logic i_right_ref_input,
   output logic o_auto_commutation,
   output logic o_high_velocity_actions,
   output logic o_position_load,
   output logic [31:0] o_position_value,
   output logic [31:0] o_step_velocity,
   output logic [cts_pkg::CTS_SW_W-1:0] o_switch_mode_config,
   output logic o_stall_stop_enable,
   output logic o_stop_left,
   output logic o_stop_right,
   output logic o_motor_stop
);
   import cts_pkg::*;

   logic bus_wr;
   logic bus_rd;
   logic [CTS_AW-1:0] bus_addr;
   logic [31:0] bus_wdata;
   logic [31:0] rd_mux;

   logic [CTS_THR_W-1:0] thr_q, thr_d;
   logic [CTS_SW_W-1:0] sw_q, sw_d;
   logic [31:0] vlim_l_q, vlim_l_d;
   logic [31:0] vlim_r_q, vlim_r_d;

   logic comm_q, comm_d;
   logic pos_load_q, pos_load_d;
   logic [31:0] pos_q, pos_d;
   logic [31:0] stepv_q, stepv_d;

   logic [31:0] vel_mag;
   logic [31:0] thr_val;
   logic thr_nz;
   logic engage;
   logic [1:0] stop_w;
   logic [1:0] vstop_w;
   logic motor_stop_w;

   ////////////////////////////////////////////////////////////////////////
   // bus front end
   cts_ahb_slave u_bus
   (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_hsel(i_hsel),
      .i_haddr(i_haddr),
      .i_htrans(i_htrans),
      .i_hwrite(i_hwrite),
      .i_hsize(i_hsize),
      .i_hwdata(i_hwdata),
      .i_hready(i_hready),
      .o_hreadyout(o_hreadyout),
      .o_hresp(o_hresp),
      .o_hrdata(o_hrdata),
      .o_wr_en(bus_wr),
      .o_rd_en(bus_rd),
      .o_addr(bus_addr),
      .o_wdata(bus_wdata),
      .i_rdata(rd_mux)
   );

   ////////////////////////////////////////////////////////////////////////
   // register file
   always_comb
   begin
      thr_d = thr_q;
      sw_d = sw_q;
      vlim_l_d = vlim_l_q;
      vlim_r_d = vlim_r_q;
      if (bus_wr)
      begin
         unique case (bus_addr)
            CTS_ADDR_COMM_THRESH:
            begin
               // low byte and upper bits are dropped on write
               thr_d = bus_wdata[CTS_THR_MSB:CTS_THR_LSB];
            end
            CTS_ADDR_SWITCH_MODE_CONFIG:
            begin
               sw_d = bus_wdata[CTS_SW_W-1:0];
            end
            CTS_ADDR_VSTOP_LEFT:
            begin
               vlim_l_d = bus_wdata;
            end
            CTS_ADDR_VSTOP_RIGHT:
            begin
               vlim_r_d = bus_wdata;
            end
            default:
            begin
               thr_d = thr_q;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         thr_q <= CTS_THR_RESET;
         sw_q <= CTS_SW_RESET;
         vlim_l_q <= CTS_LIMIT_RESET;
         vlim_r_q <= CTS_LIMIT_RESET;
      end
      else
      begin
         thr_q <= thr_d;
         sw_q <= sw_d;
         vlim_l_q <= vlim_l_d;
         vlim_r_q <= vlim_r_d;
      end
   end

   // read mux; unmapped words read as zero with an OKAY answer
   always_comb
   begin
      rd_mux = 32'h0;
      unique case (bus_addr)
         CTS_ADDR_COMM_THRESH:
         begin
            rd_mux = {9'h0, thr_q, 8'h00};
         end
         CTS_ADDR_SWITCH_MODE_CONFIG:
         begin
            rd_mux = {17'h0, sw_q};
         end
         CTS_ADDR_STATUS:
         begin
            rd_mux[CTS_ST_COMM] = comm_q;
            rd_mux[CTS_ST_STOP_L] = stop_w[0];
            rd_mux[CTS_ST_STOP_R] = stop_w[1];
            rd_mux[CTS_ST_VSTOP_L] = vstop_w[0];
            rd_mux[CTS_ST_VSTOP_R] = vstop_w[1];
            rd_mux[CTS_ST_MOTOR_STOP] = motor_stop_w;
         end
         CTS_ADDR_VSTOP_LEFT:
         begin
            rd_mux = vlim_l_q;
         end
         CTS_ADDR_VSTOP_RIGHT:
         begin
            rd_mux = vlim_r_q;
         end
         default:
         begin
            rd_mux = 32'h0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // commutation threshold
   // the most negative velocity wraps to itself; harmless, it is far above
   // any threshold that fits in bits 22:8
   assign vel_mag = i_actual_velocity[31] ? (32'h0 - i_actual_velocity)
                                          : i_actual_velocity;
   assign thr_val = {9'h0, thr_q, 8'h00};
   assign thr_nz = |thr_q;
   assign engage = thr_nz
                 & i_internal_ramp_mode
                 & ~i_step_dir_mode
                 & (vel_mag >= thr_val);

   always_comb
   begin
      comm_d = engage;
      pos_load_d = engage;
      pos_d = pos_q;
      stepv_d = vel_mag;
      if (engage)
      begin
         pos_d = i_commutation_position;
         // a loaded motor slows the sensed rate; clamp it at the threshold
         stepv_d = (i_commutation_velocity < thr_val) ? thr_val
                                                      : i_commutation_velocity;
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         comm_q <= 1'b0;
         pos_load_q <= 1'b0;
         pos_q <= 32'h0;
         stepv_q <= 32'h0;
      end
      else
      begin
         comm_q <= comm_d;
         pos_load_q <= pos_load_d;
         pos_q <= pos_d;
         stepv_q <= stepv_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // reference switches and virtual stops
   cts_ref_switch u_ref
   (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_left_ref_input(i_left_ref_input),
      .i_right_ref_input(i_right_ref_input),
      .i_switch_mode_config(sw_q),
      .i_ramp_actual_position(i_ramp_actual_position),
      .i_encoder_position(i_encoder_position),
      .i_vstop_left_limit(vlim_l_q),
      .i_vstop_right_limit(vlim_r_q),
      .o_stop(stop_w),
      .o_vstop_active(vstop_w),
      .o_motor_stop(motor_stop_w)
   );

   assign o_auto_commutation = comm_q;
   assign o_high_velocity_actions = comm_q;
   assign o_position_load = pos_load_q;
   assign o_position_value = pos_q;
   assign o_step_velocity = stepv_q;
   assign o_switch_mode_config = sw_q;
   // the stall stop itself lives elsewhere; software must set it
   assign o_stall_stop_enable = sw_q[CTS_SW_STALL_STOP];
   assign o_stop_left = stop_w[0];
   assign o_stop_right = stop_w[1];
   assign o_motor_stop = motor_stop_w;

   ////////////////////////////////////////////////////////////////////////
   a_zero_thresh_off: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      (thr_q == 15'h0) |=> !o_auto_commutation)
      else $error("commutation engaged with zero threshold");
   a_ramp_only: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      !i_internal_ramp_mode |=> !o_auto_commutation)
      else $error("commutation engaged without the ramp generator");
   a_stepdir_blocks: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      i_step_dir_mode |=> !o_auto_commutation)
      else $error("commutation engaged in step and direction mode");
   a_below_thresh: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      (vel_mag < thr_val) |=> !o_auto_commutation)
      else $error("commutation engaged below threshold");
   a_engage_reach: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      (thr_nz && i_internal_ramp_mode && !i_step_dir_mode
       && vel_mag >= thr_val)
      |=> o_auto_commutation && o_high_velocity_actions)
      else $error("commutation missed at threshold");
   a_pos_feedback: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      o_auto_commutation |-> o_position_load
      && (o_position_value == $past(i_commutation_position)))
      else $error("commutation position not written back");
   a_min_step_vel: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      o_auto_commutation |-> (o_step_velocity >= $past(thr_val)))
      else $error("step velocity fell below threshold");
   a_thresh_low_zero: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      (bus_rd && bus_addr == CTS_ADDR_COMM_THRESH)
      |=> (o_hrdata[7:0] == 8'h00) && (o_hrdata[31:23] == 9'h0))
      else $error("threshold read shows reserved bits");
endmodule

/* tb/cts_motor_model.sv */
// far-side model: left/right reference switches and the motor encoder.
// assumes the bench commands presses, switch wiring and encoder count.
`timescale 1ns/100ps
module cts_motor_model
(
   input wire logic i_press_left,
   input wire logic i_press_right,
   input wire logic i_wired_low,
   input wire logic [31:0] i_enc_cmd,
   output logic o_left_ref_input,
   output logic o_right_ref_input,
   output logic [31:0] o_encoder_position
);
   // a low-wired switch pulls its line low while pressed
   assign o_left_ref_input = i_press_left ^ i_wired_low;
   assign o_right_ref_input = i_press_right ^ i_wired_low;
   assign o_encoder_position = i_enc_cmd;
endmodule

/* tb/tb_top.sv */
// self-checking bench of the commutation threshold and switch-mode block.
// assumes an AHB-Lite master of single word transfers and a 125 MHz clock.
`timescale 1ns/100ps
module tb_top;
   import cts_pkg::*;
   localparam logic [31:0] A_THR = {22'h0, CTS_ADDR_COMM_THRESH};
   localparam logic [31:0] A_SW = {22'h0, CTS_ADDR_SWITCH_MODE_CONFIG};
   localparam logic [31:0] A_ST = {22'h0, CTS_ADDR_STATUS};
   localparam logic [31:0] A_VL = {22'h0, CTS_ADDR_VSTOP_LEFT};
   localparam logic [31:0] A_VR = {22'h0, CTS_ADDR_VSTOP_RIGHT};
   logic clk, rst, hsel, hwrite, ready, resp, ramp, sd, pl, pr, wl;
   logic lref, rref, auto, hva, pload, stall, stp_l, stp_r, mstop;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, vel, cpos, cvel, rpos, ecmd, enc;
   logic [31:0] pval, svel;
   logic [CTS_SW_W-1:0] swc;
   int error_cnt = 0;
   int total_checks = 0;

   cts_commutation_cfg cts_commutation_cfg_i (.i_clk(clk), .i_sys_rst(rst),
      .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
      .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(ready),
      .o_hreadyout(ready), .o_hresp(resp), .o_hrdata(hrdata),
      .i_actual_velocity(vel), .i_internal_ramp_mode(ramp),
      .i_step_dir_mode(sd), .i_commutation_position(cpos),
      .i_commutation_velocity(cvel), .i_ramp_actual_position(rpos),
      .i_encoder_position(enc), .i_left_ref_input(lref),
      .i_right_ref_input(rref), .o_auto_commutation(auto),
      .o_high_velocity_actions(hva), .o_position_load(pload),
      .o_position_value(pval), .o_step_velocity(svel),
      .o_switch_mode_config(swc), .o_stall_stop_enable(stall),
      .o_stop_left(stp_l), .o_stop_right(stp_r), .o_motor_stop(mstop));
   cts_motor_model cts_motor_model_i (.i_press_left(pl), .i_press_right(pr),
      .i_wired_low(wl), .i_enc_cmd(ecmd), .o_left_ref_input(lref),
      .o_right_ref_input(rref), .o_encoder_position(enc));

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   //////////////////////////////////////////////////////////////////////
   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] e,
      input logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask

   // ready is looked at mid-cycle, so the edge that follows is the one
   // at which the master sees it high
   task automatic wait_rdy;
      int n;
      n = 0;
      do
      begin
         @(negedge clk);
         n++;
      end
      while (ready !== 1'b1 && n < 50);
      if (ready !== 1'b1)
      begin
         error_cnt++;
         $display("mismatch hready expected 1 seen timeout");
         summarize();
      end
   endtask

   task automatic ahb(input logic w, input logic [31:0] a,
      input logic [31:0] d, output logic [31:0] r);
      @(posedge clk);
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      wait_rdy();
      @(posedge clk);
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      r = hrdata;
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] r;
      ahb(1'b1, a, d, r);
   endtask

   task automatic rd(input logic [31:0] a, input logic [31:0] e,
      input string what);
      logic [31:0] r;
      ahb(1'b0, a, 32'h0, r);
      chk(what, e, r);
      chk("hresp", 32'h0, {31'h0, resp});
   endtask

   // outputs follow inputs by one registered stage
   task automatic settle;
      repeat (2) @(posedge clk);
      #1;
   endtask

   task automatic mot(input logic [31:0] v, input logic rm, input logic s,
      input logic [31:0] cv);
      @(posedge clk);
      vel <= v;
      ramp <= rm;
      sd <= s;
      cvel <= cv;
      settle();
   endtask

   task automatic sw(input logic a, input logic b, input logic l);
      @(posedge clk);
      pl <= a;
      pr <= b;
      wl <= l;
      settle();
   endtask

   task automatic pos(input logic [31:0] r, input logic [31:0] e);
      @(posedge clk);
      rpos <= r;
      ecmd <= e;
      settle();
   endtask

   //////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      rd(A_THR, 32'h0, "thr_reset");
      rd(A_SW, 32'h0, "sw_reset");
      rd(A_VL, 32'h0, "vl_reset");
      wr(A_THR, 32'hFFFFFFFF);
      rd(A_THR, 32'h007FFF00, "thr_mask");
      wr(32'h10, 32'hFFFFFFFF);
      rd(32'h10, 32'h0, "unmapped");
      wr(A_SW, 32'hFFFFFFFF);
      rd(A_SW, 32'h00007FFF, "sw_rw");
      settle();
      chk("sw_port", 32'h7FFF, {17'h0, swc});
      chk("stall_en", 32'h1, {31'h0, stall});
      wr(A_SW, 32'h0);
      $display("test regs done");
   endtask

   task automatic t_comm;
      wr(A_SW, 32'h00000400);
      wr(A_THR, 32'h00000300);
      mot(32'd767, 1'b1, 1'b0, 32'd100);
      chk("auto_below", 32'h0, {31'h0, auto});
      mot(32'd768, 1'b1, 1'b0, 32'd100);
      chk("auto_reach", 32'h1, {31'h0, auto});
      chk("hv_actions", 32'h1, {31'h0, hva});
      chk("pos_load", 32'h1, {31'h0, pload});
      chk("pos_value", cpos, pval);
      chk("step_min", 32'd768, svel);
      mot(-32'sd768, 1'b1, 1'b0, 32'd1000);
      chk("auto_neg", 32'h1, {31'h0, auto});
      chk("step_load", 32'd1000, svel);
      mot(32'd768, 1'b1, 1'b1, 32'd100);
      chk("auto_stepdir", 32'h0, {31'h0, auto});
      mot(32'd768, 1'b0, 1'b0, 32'd100);
      chk("auto_noramp", 32'h0, {31'h0, auto});
      chk("load_noramp", 32'h0, {31'h0, pload});
      wr(A_THR, 32'h00400000);
      mot(32'h003FFFFF, 1'b1, 1'b0, 32'd100);
      chk("auto_big_lo", 32'h0, {31'h0, auto});
      mot(32'h00400000, 1'b1, 1'b0, 32'd100);
      chk("auto_big_hi", 32'h1, {31'h0, auto});
      wr(A_THR, 32'h0);
      mot(32'h7FFFFFFF, 1'b1, 1'b0, 32'd100);
      settle();
      chk("auto_zero", 32'h0, {31'h0, auto});
      $display("test comm done");
   endtask

   task automatic t_sw;
      wr(A_SW, 32'h3);
      sw(1'b1, 1'b0, 1'b0);
      chk("stop_l_on", 32'h1, {31'h0, stp_l});
      chk("stop_r_off", 32'h0, {31'h0, stp_r});
      chk("mstop_on", 32'h1, {31'h0, mstop});
      sw(1'b0, 1'b0, 1'b0);
      chk("stop_l_rel", 32'h0, {31'h0, stp_l});
      chk("mstop_rel", 32'h0, {31'h0, mstop});
      wr(A_SW, 32'hF);
      sw(1'b1, 1'b1, 1'b1);
      chk("pol_low_l", 32'h1, {31'h0, stp_l});
      chk("pol_low_r", 32'h1, {31'h0, stp_r});
      sw(1'b0, 1'b0, 1'b1);
      chk("pol_idle", 32'h0, {31'h0, stp_l | stp_r});
      wr(A_SW, 32'h11);
      sw(1'b0, 1'b1, 1'b0);
      chk("swap_on", 32'h1, {31'h0, stp_l});
      sw(1'b1, 1'b0, 1'b0);
      chk("swap_off", 32'h0, {31'h0, stp_l});
      sw(1'b0, 1'b0, 1'b0);
      $display("test switch done");
   endtask

   task automatic t_vstop;
      wr(A_VL, 32'd100);
      wr(A_VR, 32'd1000);
      rd(A_VR, 32'd1000, "vr_rw");
      pos(32'd50, 32'd500);
      wr(A_SW, 32'h3000);
      settle();
      chk("vstop_l", 32'h1, {31'h0, mstop});
      rd(A_ST, 32'h2A, "status_vl");
      pos(32'd500, 32'd50);
      chk("src_ramp", 32'h0, {31'h0, mstop});
      pos(32'd2000, 32'd50);
      chk("vstop_r", 32'h1, {31'h0, stp_r});
      wr(A_SW, 32'h7000);
      settle();
      chk("src_enc", 32'h1, {31'h0, mstop});
      chk("src_enc_rnot", 32'h0, {31'h0, stp_r});
      pos(32'd50, 32'd2000);
      chk("src_enc_r", 32'h1, {31'h0, mstop});
      wr(A_SW, 32'h4000);
      settle();
      chk("vstop_off", 32'h0, {31'h0, mstop});
      $display("test vstop done");
   endtask

   initial
   begin
      rst = 1'b1;
      hsel = 1'b1;
      htrans = 2'h0;
      haddr = 32'h0;
      hwrite = 1'b0;
      hsize = CTS_HSIZE_WORD;
      hwdata = 32'h0;
      vel = 32'h0;
      ramp = 1'b0;
      sd = 1'b0;
      cpos = 32'h12345678;
      cvel = 32'h0;
      rpos = 32'h0;
      ecmd = 32'h0;
      pl = 1'b0;
      pr = 1'b0;
      wl = 1'b0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_comm();
      t_sw();
      t_vstop();
      summarize();
   end
endmodule
